// file: dma_remap_request_screening.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: split page-crossing requests when platform does not
// RULE_02: receiver-checked crossings become malformed packet errors
// RULE_03: zero-length read translated normally when cap clear
// RULE_04: successful zero-length read completes, byte enables off
// RULE_05: cap clear: write-only page read blocked
// RULE_06: cap set: write-only zero-length read succeeds
// RULE_07: relaxed zero-length read data is obfuscated
// RULE_08: advertise relaxed zero-length read cap set
// RULE_09: non-PASID one-dword window write is interrupt
// RULE_10: interrupt requests bypass address translation
// RULE_11: other non-PASID window requests are errors
// RULE_12: interrupts go to interrupt remapping when enabled
// RULE_13: PASID window requests translate normally
// RULE_14: software never maps into interrupt window
// RULE_15: reserved memory not found by address decode
// RULE_16: software sets identity maps for reserved ranges
// RULE_17: peer decode uses translated address only
// RULE_18: peer forwarding limited to region or off
// RULE_19: forwarded peer packet gets recomputed ECRC
// RULE_20: illegal window requests discarded, non-posted failed
module dma_remap_request_screening #(
  parameter logic RELAX_CAP = 1'b1,            // relaxed zero-length read support
  parameter logic PLAT_CHK = 1'b0              // platform blocks page crossings itself
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rstn,
  // inbound request
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire screen_pkg::kind_t                 req_kind,
  input  wire logic [screen_pkg::ADDR_W-1:0]     req_addr,
  input  wire logic [screen_pkg::LEN_W-1:0]      req_len,
  input  wire logic [3:0]                        req_first_be,
  input  wire logic                              req_pasid,
  input  wire logic                              req_pcie_rx,   // arrived at a receiver port
  // configuration levels
  input  wire logic                              irq_remap_en,
  input  wire logic                              p2p_en,
  input  wire logic [screen_pkg::ADDR_W-1:0]     p2p_base,
  input  wire logic [screen_pkg::ADDR_W-1:0]     p2p_limit,
  // screened request to translation
  output logic                                   xl_valid,
  input  wire logic                              xl_ready,
  output logic [screen_pkg::ADDR_W-1:0]          xl_addr,
  output logic [screen_pkg::LEN_W-1:0]           xl_len,
  output logic                                   xl_last,
  output logic                                   xl_zlr,
  output logic                                   xl_is_read,
  // translation result
  input  wire logic                              xr_valid,
  input  wire screen_pkg::xres_t                 xr_res,
  input  wire logic [screen_pkg::ADDR_W-1:0]     xr_hpa,
  input  wire logic                              xr_zlr,
  input  wire logic                              xr_peer,      // hpa decodes to a peer
  input  wire logic [31:0]                       xr_rdata,
  input  wire logic                              xr_ecrc_in,
  // results
  output logic                                   cpl_valid,
  output logic                                   cpl_ok,
  output logic [3:0]                             cpl_be,
  output logic [31:0]                            cpl_data,
  output logic                                   fault_valid,
  output logic                                   peer_fwd,
  output logic                                   peer_ecrc_regen,
  output logic [screen_pkg::ADDR_W-1:0]          peer_addr,
  output logic                                   irq_valid,
  output logic                                   irq_to_remap,
  output logic [31:0]                            irq_addr,
  output logic                                   err_malformed,
  output logic                                   err_illegal,
  output logic                                   ur_cpl,
  output logic                                   zero_length_read_relaxed_cap
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  assign zero_length_read_relaxed_cap = RELAX_CAP;  // [RULE_08]

  // ****************************************************************
  // classification
  // ****************************************************************
  logic in_win;
  logic one_dw;
  logic crosses;
  logic is_irq;
  logic illegal;
  logic is_zlr;
  screen_pkg::route_t route;

  // window decode only on untranslated non-PASID input
  assign in_win  = (req_addr[31:screen_pkg::IRQ_WIN_LSB] == screen_pkg::IRQ_WIN_BASE)
                   && (req_addr[screen_pkg::ADDR_W-1:32] == '0);
  assign one_dw  = (req_len == screen_pkg::LEN_ONE);
  assign crosses = (int'(req_addr[11:0]) + 4 * int'(req_len)) > screen_pkg::PAGE_BYTES;
  assign is_irq  = !req_pasid && in_win && (req_kind == screen_pkg::KIND_WRITE) && one_dw;  // [RULE_09]
  assign illegal = !req_pasid && in_win && !is_irq;                                         // [RULE_11]
  assign is_zlr  = (req_kind == screen_pkg::KIND_READ) && one_dw
                   && (req_first_be == screen_pkg::BE_NONE);                               // [RULE_03]

  // routing decision; PASID requests fall through to translation unless they are receiver-checked page crossings
  always_comb begin
    if (crosses && (PLAT_CHK || req_pcie_rx)) begin
      route = screen_pkg::ROUTE_MALFORM;                 // [RULE_02]
    end else if (is_irq) begin
      route = screen_pkg::ROUTE_IRQ;                     // [RULE_10]
    end else if (illegal) begin
      route = (req_kind == screen_pkg::KIND_WRITE) ? screen_pkg::ROUTE_DROP
                                                   : screen_pkg::ROUTE_UR_CPL;  // [RULE_20]
    end else begin
      route = screen_pkg::ROUTE_XLATE;                   // [RULE_13]
    end
  end

  // ****************************************************************
  // splitter towards translation
  // ****************************************************************
  screen_if sif ();
  logic zlr_q;
  logic rd_q;

  assign sif.in_valid  = req_valid && (route == screen_pkg::ROUTE_XLATE);
  assign sif.in_addr   = req_addr;
  assign sif.in_len    = req_len;
  assign sif.out_ready = xl_ready;
  assign req_ready     = sif.in_ready;

  page_splitter u_split (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sp      (sif.splitter)
  );

  // crossing requests reach translation one page at a time
  assign xl_valid   = sif.out_valid;   // [RULE_01]
  assign xl_addr    = sif.out_addr;
  assign xl_len     = sif.out_len;
  assign xl_last    = sif.out_last;
  assign xl_zlr     = zlr_q;
  assign xl_is_read = rd_q;

  // request attributes held while pieces are emitted
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zlr_q <= 1'b0;
      rd_q  <= 1'b0;
    end else if (sif.in_valid && sif.in_ready) begin
      zlr_q <= is_zlr;
      rd_q  <= (req_kind == screen_pkg::KIND_READ);
    end
  end

  // ****************************************************************
  // front-end events
  // ****************************************************************
  logic acc;
  assign acc = req_valid && req_ready;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_valid     <= 1'b0;
      irq_to_remap  <= 1'b0;
      irq_addr      <= '0;
      err_malformed <= 1'b0;
      err_illegal   <= 1'b0;
      ur_cpl        <= 1'b0;
    end else begin
      irq_valid     <= acc && (route == screen_pkg::ROUTE_IRQ);
      irq_to_remap  <= acc && (route == screen_pkg::ROUTE_IRQ) && irq_remap_en;   // [RULE_12]
      if (acc && route == screen_pkg::ROUTE_IRQ) begin
        irq_addr <= req_addr[31:0];
      end
      err_malformed <= acc && (route == screen_pkg::ROUTE_MALFORM);
      err_illegal   <= acc && (route == screen_pkg::ROUTE_DROP || route == screen_pkg::ROUTE_UR_CPL);
      ur_cpl        <= acc && (route == screen_pkg::ROUTE_UR_CPL);                // [RULE_20]
    end
  end

  // ****************************************************************
  // translation result handling
  // ****************************************************************
  logic zlr_pass;
  logic in_region;
  // relaxed mode lets a read-permission-only fault through for zero-length reads
  assign zlr_pass  = xr_zlr && RELAX_CAP && (xr_res == screen_pkg::XR_NO_READ); // [RULE_05] [RULE_06]
  // peer decode on the translated address, never the input address
  assign in_region = (xr_hpa >= p2p_base) && (xr_hpa <= p2p_limit);             // [RULE_17] [RULE_18]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpl_valid       <= 1'b0;
      cpl_ok          <= 1'b0;
      cpl_be          <= 4'h0;
      cpl_data        <= '0;
      fault_valid     <= 1'b0;
      peer_fwd        <= 1'b0;
      peer_ecrc_regen <= 1'b0;
      peer_addr       <= '0;
    end else begin
      cpl_valid       <= xr_valid && xr_zlr;
      cpl_ok          <= xr_valid && xr_zlr && (xr_res == screen_pkg::XR_OK || zlr_pass);
      cpl_be          <= screen_pkg::BE_NONE;                                   // [RULE_04]
      cpl_data        <= zlr_pass ? screen_pkg::OBF_FILL : xr_rdata;           // [RULE_07]
      fault_valid     <= xr_valid && (xr_res != screen_pkg::XR_OK) && !zlr_pass; // [RULE_03]
      peer_fwd        <= xr_valid && (xr_res == screen_pkg::XR_OK) && xr_peer && p2p_en && in_region;
      peer_ecrc_regen <= xr_valid && (xr_res == screen_pkg::XR_OK) && xr_peer && p2p_en && in_region
                         && xr_ecrc_in;                                         // [RULE_19]
      if (xr_valid) begin
        peer_addr <= xr_hpa;
      end
    end
  end

  // reserved memory is not recognised by any address decode here; it relies on
  // identity maps that software installs in translation tables
  // [RULE_15] [RULE_16] [RULE_14]

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence irq_take_s;
    acc && is_irq;
  endsequence

  irq_handoff_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_take_s |=> irq_valid && !xl_valid) else $error("interrupt not handed off");  // [RULE_09]
  irq_no_xlate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && is_irq |-> !sif.in_valid) else $error("interrupt sent to translation");   // [RULE_10]
  illegal_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && illegal && !crosses |=> err_illegal && !irq_valid) else $error("illegal not flagged"); // [RULE_11]
  irq_remap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_take_s |=> irq_to_remap == $past(irq_remap_en)) else $error("remap handoff wrong");  // [RULE_12]
  ur_nonposted_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && illegal && !crosses && req_kind != screen_pkg::KIND_WRITE |=> ur_cpl)
    else $error("no failed completion");  // [RULE_20]
  pasid_win_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && req_pasid && !crosses |-> sif.in_valid) else $error("pasid not translated"); // [RULE_13]
  zlr_be_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpl_valid |-> cpl_be == 4'h0) else $error("zero-length completion with bytes"); // [RULE_04]
  zlr_relax_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    xr_valid && xr_zlr && xr_res == screen_pkg::XR_NO_READ |=> cpl_ok == RELAX_CAP && fault_valid == !RELAX_CAP)
    else $error("write-only zero-length read wrong");  // [RULE_05] [RULE_06]
  malform_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && crosses && req_pcie_rx |=> err_malformed) else $error("crossing not malformed"); // [RULE_02]
  peer_region_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    peer_fwd |-> $past(p2p_en) && $past(in_region)) else $error("peer outside region");  // [RULE_18]
endmodule // dma_remap_request_screening
`default_nettype wire

// file: dma_remap_request_screening_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_remap_request_screening_tb;
  typedef struct packed {logic [3:0] k; logic [95:0] v; logic [95:0] m;} note_t;
  localparam logic [95:0] ALL  = {96{1'b1}};
  localparam logic [63:0] OFFS = 64'h0000_0001_0000_0000;
  localparam logic [63:0] P_LO = 64'h0000_0001_0010_0000;
  localparam logic [63:0] P_HI = 64'h0000_0001_001F_FFFF;
  logic clk_sys, rstn, req_valid, req_ready, req_pasid, req_pcie_rx, irq_remap_en, p2p_en, peer_mode;
  logic xl_valid, xl_ready, xl_last, xl_zlr, xl_is_read, xr_valid, xr_zlr, xr_peer, xr_ecrc_in;
  logic cpl_valid, cpl_ok, fault_valid, peer_fwd, peer_ecrc_regen, irq_valid, irq_to_remap;
  logic err_malformed, err_illegal, ur_cpl, zero_length_read_relaxed_cap;
  logic [63:0] req_addr, p2p_base, p2p_limit, xl_addr, xr_hpa, peer_addr;
  logic [9:0] req_len, xl_len;
  logic [3:0] req_first_be, cpl_be, lag;
  logic [31:0] xr_rdata, cpl_data, irq_addr;
  screen_pkg::kind_t req_kind;
  screen_pkg::xres_t xr_res, res_mode;
  note_t notes[$];
  int err_total, tests_run, cyc;

  dma_remap_request_screening #(.RELAX_CAP(1'b1), .PLAT_CHK(1'b0)) dma_remap_request_screening_inst (
    .clk_sys, .rstn, .req_valid, .req_ready, .req_kind, .req_addr, .req_len, .req_first_be, .req_pasid,
    .req_pcie_rx, .irq_remap_en, .p2p_en, .p2p_base, .p2p_limit, .xl_valid, .xl_ready, .xl_addr, .xl_len,
    .xl_last, .xl_zlr, .xl_is_read, .xr_valid, .xr_res, .xr_hpa, .xr_zlr, .xr_peer, .xr_rdata, .xr_ecrc_in,
    .cpl_valid, .cpl_ok, .cpl_be, .cpl_data, .fault_valid, .peer_fwd, .peer_ecrc_regen, .peer_addr,
    .irq_valid, .irq_to_remap, .irq_addr, .err_malformed, .err_illegal, .ur_cpl, .zero_length_read_relaxed_cap);
  xlate_model xlate_model_inst (.clk_sys, .rstn, .xl_valid, .xl_addr, .xl_zlr, .xl_ready, .res_mode,
    .peer_mode, .lag, .xr_valid, .xr_res, .xr_hpa, .xr_zlr, .xr_peer, .xr_rdata);

  // ****************************************************************
  // clock, notes and comparisons
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic note(logic [3:0] k, logic [95:0] v, logic [95:0] m = ALL);
    notes.push_back('{k, v, m});
  endtask

  task automatic cmp_note(logic [3:0] k, logic [95:0] v);
    note_t n;
    tests_run++;
    n = (notes.size() != 0) ? notes.pop_front() : '{4'hF, 96'h0, 96'h0};
    if (n.k !== k || (n.v & n.m) !== (v & n.m)) begin
      err_total++;
      $display("wrong value event expected %0d/%h seen %0d/%h", n.k, n.v & n.m, k, v & n.m);
    end
  endtask

  task automatic cmp_bit(string name, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", name, e, g);
    end
  endtask

  // result of one translated piece, from partner mode and peer window
  task automatic expect_res(logic [63:0] pa, logic z);
    logic [63:0] hpa;
    hpa = pa + OFFS;
    if (z) note(4'h6, {59'h0, res_mode != screen_pkg::XR_FAULT, 36'h0},
                {59'h0, 1'b1, {4{res_mode != screen_pkg::XR_FAULT}}, {32{res_mode == screen_pkg::XR_NO_READ}}});
    if (res_mode == screen_pkg::XR_FAULT) note(4'h7, 96'h0);
    else if (peer_mode && p2p_en && hpa >= P_LO && hpa <= P_HI) note(4'h8, {31'h0, xr_ecrc_in, hpa});
  endtask

  // one piece per 4KB page, each followed by its result
  task automatic expect_xlate(logic [63:0] a, logic [9:0] l, logic z);
    int rem, room, pl;
    logic [63:0] pa;
    pa = a;
    rem = l;
    while (rem != 0) begin
      room = (4096 - pa[11:0]) / 4;
      pl = rem < room ? rem : room;
      rem -= pl;
      note(rem == 0 ? 4'h2 : 4'h1, {21'h0, z, 10'(pl), pa});
      expect_res(pa, z);
      pa += 64'(pl * 4);
    end
  endtask

  // request held until taken at an edge with ready high
  task automatic send(screen_pkg::kind_t k, logic [63:0] a, logic [9:0] l, logic [3:0] be, logic p, logic rx);
    req_valid    <= 1'b1;
    req_kind     <= k;
    req_addr     <= a;
    req_len      <= l;
    req_first_be <= be;
    req_pasid    <= p;
    req_pcie_rx  <= rx;
    do @(negedge clk_sys); while (req_ready !== 1'b1);
    @(posedge clk_sys);
  endtask

  task automatic idle();
    req_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic settle();
    int i;
    idle();
    for (i = 0; i < 400 && notes.size() != 0; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask

  // monitor: every result takes the oldest note
  always @(posedge clk_sys) begin
    if (rstn) begin
      if (xl_valid && xl_ready) cmp_note(xl_last ? 4'h2 : 4'h1, {21'h0, xl_zlr, xl_len, xl_addr});
      if (irq_valid) cmp_note(4'h3, {63'h0, irq_to_remap, irq_addr});
      if (err_malformed) cmp_note(4'h4, 96'h0);
      if (err_illegal) cmp_note(4'h5, {95'h0, ur_cpl});
      if (cpl_valid) cmp_note(4'h6, {59'h0, cpl_ok, cpl_be, cpl_data});
      if (fault_valid) cmp_note(4'h7, 96'h0);
      if (peer_fwd) cmp_note(4'h8, {31'h0, peer_ecrc_regen, peer_addr});
    end
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [63:0] a;
    logic [9:0]  l;
    void'($urandom(32'h7D48));
    {rstn, req_valid, req_pasid, req_pcie_rx, p2p_en, peer_mode, xr_ecrc_in} = 7'h00;
    {req_addr, req_len, req_first_be, lag} = '0;
    req_kind = screen_pkg::KIND_WRITE;
    res_mode = screen_pkg::XR_OK;
    irq_remap_en = 1'b1;
    p2p_base = P_LO;
    p2p_limit = P_HI;
    {err_total, tests_run, cyc} = '0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp_bit("relaxed_cap", 1'b1, zero_length_read_relaxed_cap);
    expect_xlate(64'h1FF8, 10'h004, 1'b0);
    send(screen_pkg::KIND_WRITE, 64'h1FF8, 10'h004, 4'hF, 1'b0, 1'b0);
    settle();
    for (int i = 0; i < 6; i++) begin
      a = {40'h0, 22'($urandom), 2'b00};
      l = 10'($urandom_range(1, 1023));
      lag <= 4'($urandom);
      idle();
      expect_xlate(a, l, 1'b0);
      send(screen_pkg::KIND_WRITE, a, l, 4'hF, 1'b0, 1'b0);
      settle();
    end
    note(4'h4, 96'h0);
    send(screen_pkg::KIND_WRITE, 64'h0FFC, 10'h002, 4'hF, 1'b0, 1'b1);
    settle();
    for (int r = 0; r < 3; r++) begin
      res_mode <= screen_pkg::xres_t'(r[1:0]);
      idle();
      expect_xlate(64'h3000, 10'h001, 1'b1);
      send(screen_pkg::KIND_READ, 64'h3000, 10'h001, 4'h0, 1'b0, 1'b0);
      settle();
    end
    res_mode <= screen_pkg::XR_OK;
    for (int e = 0; e < 2; e++) begin
      irq_remap_en <= e[0];
      idle();
      note(4'h3, {63'h0, e[0], 32'hFEE0_1000});
      note(4'h3, {63'h0, e[0], 32'hFEE0_2004});
      send(screen_pkg::KIND_WRITE, 64'hFEE0_1000, 10'h001, 4'hF, 1'b0, 1'b0);
      send(screen_pkg::KIND_WRITE, 64'hFEE0_2004, 10'h001, 4'hF, 1'b0, 1'b0);
      settle();
    end
    note(4'h5, 96'h1);
    note(4'h5, 96'h1);
    note(4'h5, 96'h0);
    send(screen_pkg::KIND_READ, 64'hFEE0_0000, 10'h001, 4'hF, 1'b0, 1'b0);
    send(screen_pkg::KIND_ATOMIC, 64'hFEE0_0010, 10'h001, 4'hF, 1'b0, 1'b0);
    send(screen_pkg::KIND_WRITE, 64'hFEE0_0020, 10'h002, 4'hF, 1'b0, 1'b0);
    settle();
    expect_xlate(64'hFEE0_0040, 10'h001, 1'b0);
    send(screen_pkg::KIND_WRITE, 64'hFEE0_0040, 10'h001, 4'hF, 1'b1, 1'b0);
    settle();
    peer_mode <= 1'b1;
    xr_ecrc_in <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      p2p_en <= e[0];
      idle();
      expect_xlate(64'h0010_0100, 10'h001, 1'b0);
      expect_xlate(64'h0000_0001_0010_0100, 10'h001, 1'b0);
      send(screen_pkg::KIND_WRITE, 64'h0010_0100, 10'h001, 4'hF, 1'b0, 1'b0);
      send(screen_pkg::KIND_WRITE, 64'h0000_0001_0010_0100, 10'h001, 4'hF, 1'b0, 1'b0);
      settle();
    end
    err_total += notes.size();
    wrap_up();
  end
endmodule // dma_remap_request_screening_tb
`default_nettype wire

// file: page_splitter.sv
`timescale 1ns/1ps
`default_nettype none
// splits a request that crosses 4KB pages into one piece per page
module page_splitter (
  input  wire logic    clk_sys,
  input  wire logic    rst_n,
  screen_if.splitter   sp
);
  localparam int AW = screen_pkg::ADDR_W;
  localparam int LW = screen_pkg::LEN_W;

  screen_pkg::split_t st_q;
  logic [AW-1:0]      addr_q;
  logic [LW-1:0]      rem_q;
  logic [LW:0]        room;   // one bit wider: a full page is 1024 dwords
  logic [LW-1:0]      piece;

  // dwords left before the next page boundary
  assign room  = (LW+1)'((screen_pkg::PAGE_BYTES - int'(addr_q[screen_pkg::PAGE_SHIFT-1:0])) >> 2);
  assign piece = ({1'b0, rem_q} > room) ? LW'(room) : rem_q;

  assign sp.in_ready  = (st_q == screen_pkg::SP_IDLE);
  assign sp.out_valid = (st_q == screen_pkg::SP_EMIT);
  assign sp.out_addr  = addr_q;
  assign sp.out_len   = piece;
  assign sp.out_last  = (piece == rem_q);

  // ****************************************************************
  // piece sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= screen_pkg::SP_IDLE;
      addr_q <= '0;
      rem_q  <= '0;
    end else begin
      case (st_q)
        screen_pkg::SP_IDLE: begin
          if (sp.in_valid) begin
            addr_q <= sp.in_addr;
            rem_q  <= sp.in_len;
            st_q   <= screen_pkg::SP_EMIT;
          end
        end
        screen_pkg::SP_EMIT: begin
          if (sp.out_ready) begin
            addr_q <= addr_q + AW'({piece, 2'b00});
            rem_q  <= rem_q - piece;
            if (piece == rem_q) begin
              st_q <= screen_pkg::SP_IDLE;
            end
          end
        end
        default: st_q <= screen_pkg::SP_IDLE;
      endcase
    end
  end

  // every piece stays inside one page
  piece_in_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sp.out_valid |-> (int'(sp.out_addr[11:0]) + 4 * int'(sp.out_len)) <= screen_pkg::PAGE_BYTES)
    else $error("split piece crosses a page");
endmodule // page_splitter
`default_nettype wire

// file: screen_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// page splitter carrier
// ****************************************************************
interface screen_if;
  logic                                   in_valid;
  logic                                   in_ready;
  logic [screen_pkg::ADDR_W-1:0]          in_addr;
  logic [screen_pkg::LEN_W-1:0]           in_len;
  logic                                   out_valid;
  logic                                   out_ready;
  logic [screen_pkg::ADDR_W-1:0]          out_addr;
  logic [screen_pkg::LEN_W-1:0]           out_len;
  logic                                   out_last;
  modport splitter (input in_valid, in_addr, in_len, out_ready,
                    output in_ready, out_valid, out_addr, out_len, out_last);
  modport user (output in_valid, in_addr, in_len, out_ready,
                input in_ready, out_valid, out_addr, out_len, out_last);
endinterface
`default_nettype wire

// file: screen_pkg.sv
package screen_pkg;

  // ****************************************************************
  // request fields and encodings
  // ****************************************************************
  localparam int          ADDR_W         = 64;
  localparam int          LEN_W          = 10;            // length in dwords
  localparam int          PAGE_SHIFT     = 12;            // 4KB page
  localparam int          PAGE_BYTES     = 4096;
  localparam logic [11:0] IRQ_WIN_BASE   = 12'hFEE;       // address bits 31:20
  localparam int          IRQ_WIN_LSB    = 20;
  localparam logic [3:0]  BE_NONE        = 4'h0;
  localparam logic [LEN_W-1:0] LEN_ONE   = 10'h001;

  // request kinds
  typedef enum logic [1:0] {
    KIND_READ   = 2'b00,
    KIND_WRITE  = 2'b01,
    KIND_ATOMIC = 2'b10
  } kind_t;

  // routing outcome of a screened request
  typedef enum logic [2:0] {
    ROUTE_XLATE   = 3'b000,  // forward to translation
    ROUTE_IRQ     = 3'b001,  // hand to interrupt remapping / interrupt logic
    ROUTE_DROP    = 3'b010,  // discarded, no completion
    ROUTE_UR_CPL  = 3'b011,  // discarded, unsuccessful completion
    ROUTE_MALFORM = 3'b100   // malformed packet, error reported
  } route_t;

  // translation result kinds
  typedef enum logic [1:0] {
    XR_OK      = 2'b00,
    XR_NO_READ = 2'b01,     // only fault is missing read permission
    XR_FAULT   = 2'b10
  } xres_t;

  // obfuscation pattern for relaxed zero-length read data
  localparam logic [31:0] OBF_FILL       = 32'h0000_0000;

  // page crossing split state machine
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_EMIT = 2'b01
  } split_t;

endpackage

// file: xlate_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// translation stage stand-in, one piece at a time
// ****************************************************************
module xlate_model (
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  input  wire logic                          xl_valid,
  input  wire logic [screen_pkg::ADDR_W-1:0] xl_addr,
  input  wire logic                          xl_zlr,
  output logic                               xl_ready,
  input  wire screen_pkg::xres_t             res_mode,
  input  wire logic                          peer_mode,
  input  wire logic [3:0]                    lag,
  output logic                               xr_valid,
  output screen_pkg::xres_t                  xr_res,
  output logic [screen_pkg::ADDR_W-1:0]      xr_hpa,
  output logic                               xr_zlr,
  output logic                               xr_peer,
  output logic [31:0]                        xr_rdata
);
  localparam logic [63:0] HPA_OFFS = 64'h0000_0001_0000_0000;
  logic [4:0]  cnt_q;
  logic        busy_q;
  logic [63:0] addr_q;
  logic        zlr_q;

  // take a piece, answer lag+1 cycles after the take, rest two cycles before the next
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_q   <= 1'b0;
      cnt_q    <= 5'h00;
      xl_ready <= 1'b0;
      xr_valid <= 1'b0;
    end else begin
      xr_valid <= 1'b0;
      if (!busy_q) begin
        xl_ready <= 1'b1;
        if (xl_valid && xl_ready) begin
          busy_q   <= 1'b1;
          xl_ready <= 1'b0;
          cnt_q    <= {1'b0, lag};
          addr_q   <= xl_addr;
          zlr_q    <= xl_zlr;
        end
      end else begin
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h00) xr_valid <= 1'b1;
        if (cnt_q == 5'h1E) busy_q <= 1'b0;
      end
    end
  end

  // answer fields; outside the pulse hpa, zlr, peer and rdata show inverted junk, res always follows res_mode
  assign xr_res   = res_mode;
  assign xr_hpa   = xr_valid ? addr_q + HPA_OFFS : ~addr_q;  // mapping keeps clear of the irq window
  assign xr_zlr   = xr_valid ? zlr_q : ~zlr_q;
  assign xr_peer  = xr_valid ? peer_mode : ~peer_mode;
  assign xr_rdata = xr_valid ? 32'hC3A5_96E1 : 32'h3C5A_691E;
endmodule // xlate_model
`default_nettype wire
